//--- hw/acs_top.sv
// acs_top: conversion sequencer with AXI4-Lite registers
`timescale 1ns/1ps
module acs_top #(
  parameter int DATA_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic ext_trigger,
  input wire logic core_ready,
  output logic core_enable,
  output logic [1:0] sample_speed,
  output logic conv_start,
  output logic [3:0] channel_select,
  input wire logic conv_done,
  input wire logic [DATA_W-1:0] conv_data,
  output logic irq
);
  import acs_pkg::*;

  // bus slave state
  logic aw_v_q, aw_v_d, w_v_q, w_v_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0] aw_a_q, aw_a_d;
  logic [31:0] w_d_q, w_d_d, rd_q, rd_d;
  logic [3:0] w_s_q, w_s_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  // configuration
  logic en_q, en_d, accum_enable_q, accum_enable_d;
  logic [2:0] mode_q, mode_d, len_q, len_d;
  logic [1:0] spd_q, spd_d;
  logic [3:0] chsel_q, chsel_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, done_q, done_d;
  logic [3:0] slot_ch_q [SLOTS], slot_ch_d [SLOTS]; // per-slot channel picks
  logic [3:0] ien_q, ien_d;
  // run state and results
  logic run_q, run_d;
  logic [3:0] flag_q, flag_d;
  logic [31:0] acc_q, acc_d;
  logic [DATA_W-1:0] res_q [SLOTS], res_d [SLOTS];
  logic [2:0] slot_q, slot_d;
  acs_state_t st_q, st_d;
  logic start_q, start_d;
  logic [3:0] ch_q, ch_d;
  logic trig_prev_q;
  // synchronised pins
  logic [1:0] pins;
  logic do_wr, wr_ok;
  logic [31:0] wmask;

  acs_sync #(.W(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin({core_ready, ext_trigger}),
    .level(pins)
  );

  assign awready = !aw_v_q;
  assign wready = !w_v_q;
  assign arready = !rv_q;
  assign bvalid = bv_q;
  assign bresp = br_q;
  assign rvalid = rv_q;
  assign rdata = rd_q;
  assign rresp = rr_q;
  assign core_enable = en_q;
  assign sample_speed = spd_q;
  assign conv_start = start_q;
  assign channel_select = ch_q;
  assign irq = |(flag_q[F_SEQ:F_CONV] & ien_q[F_SEQ:F_CONV]);

  // write fires once address and data are both held and no response is pending
  assign do_wr = aw_v_q && w_v_q && !bv_q;
  assign wr_ok = (aw_a_q[1:0] == 2'b00) && (aw_a_q <= OFS_IEN);
  assign wmask = {{8{w_s_q[3]}}, {8{w_s_q[2]}}, {8{w_s_q[1]}}, {8{w_s_q[0]}}};

  // merge written bytes into the stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // read mux: unmapped words read zero
  function automatic logic [31:0] rmux(input logic [7:0] a);
    rmux = '0;
    case (a)
      OFS_MAIN: rmux = {26'h000_0000, spd_q, mode_q, en_q};
      OFS_CHAN: rmux = {28'h000_0000, chsel_q};
      OFS_REP: rmux = {22'h00_0000, 1'b0, accum_enable_q, cnt_q};
      OFS_SEQL: rmux = {13'h0000, len_q, slot_ch_q[3], slot_ch_q[2], slot_ch_q[1],
                        slot_ch_q[0]};
      OFS_SEQH: rmux = {16'h0000, slot_ch_q[7], slot_ch_q[6], slot_ch_q[5], slot_ch_q[4]};
      OFS_RUN: rmux = {31'h0000_0000, run_q};
      OFS_STAT: rmux = {28'h000_0000, flag_q};
      OFS_IEN: rmux = {28'h000_0000, ien_q};
      OFS_ACC: rmux = acc_q;
      default: begin
        if (a >= OFS_RES0 && a < OFS_RES0 + 8'h20) begin
          rmux = 32'(res_q[a[4:2]]);
        end
      end
    endcase
  endfunction : rmux

  // bus channels: one write and one read at a time
  always_comb begin
    aw_v_d = aw_v_q;
    aw_a_d = aw_a_q;
    w_v_d = w_v_q;
    w_d_d = w_d_q;
    w_s_d = w_s_q;
    bv_d = bv_q;
    br_d = br_q;
    rv_d = rv_q;
    rd_d = rd_q;
    rr_d = rr_q;
    if (awvalid && awready) begin
      aw_v_d = 1'b1;
      aw_a_d = awaddr;
    end
    if (wvalid && wready) begin
      w_v_d = 1'b1;
      w_d_d = wdata;
      w_s_d = wstrb;
    end
    if (do_wr) begin
      aw_v_d = 1'b0;
      w_v_d = 1'b0;
      bv_d = 1'b1;
      br_d = wr_ok ? 2'b00 : 2'b10; // slave error on unmapped write
    end else if (bv_q && bready) begin
      bv_d = 1'b0;
    end
    if (arvalid && arready) begin
      rv_d = 1'b1;
      rd_d = rmux(araddr);
      rr_d = (araddr[1:0] == 2'b00 && araddr < OFS_RES0 + 8'h20 &&
              (araddr <= OFS_ACC || araddr >= OFS_RES0)) ? 2'b00 : 2'b10;
    end else if (rv_q && rready) begin
      rv_d = 1'b0;
    end
  end

  // registers, sequencer and flags
  always_comb begin
    logic [31:0] m;
    logic last;
    logic [3:0] hs; // flags that hardware sets in this cycle
    m = '0;
    last = 1'b0;
    hs = 4'h0;
    en_d = en_q;
    mode_d = mode_q;
    spd_d = spd_q;
    chsel_d = chsel_q;
    cnt_d = cnt_q;
    accum_enable_d = accum_enable_q;
    len_d = len_q;
    slot_ch_d = slot_ch_q;
    ien_d = ien_q;
    run_d = run_q;
    flag_d = flag_q;
    acc_d = acc_q;
    res_d = res_q;
    slot_d = slot_q;
    st_d = st_q;
    done_d = done_q;
    start_d = 1'b0;
    ch_d = ch_q;
    flag_d[F_READY] = en_q && pins[1];
    // converter side: a finished conversion sets flags before software clears
    if (st_q == ST_WAIT && conv_done) begin
      st_d = ST_IDLE;
      hs[F_CONV] = 1'b1;
      case (mode_q)
        MODE_REPEAT: begin
          res_d[0] = conv_data;
          if (accum_enable_q) begin
            acc_d = acc_q + 32'(conv_data);
          end
          done_d = done_q + 1'b1;
          if (done_q + 1'b1 >= cnt_q) begin
            hs[F_ALL] = 1'b1;
            run_d = 1'b0;
            done_d = '0;
          end
        end
        MODE_CONT: begin
          res_d[0] = conv_data;
        end
        MODE_SEQ: begin
          res_d[slot_q] = conv_data;
          last = (slot_q >= len_q);
          slot_d = last ? 3'h0 : slot_q + 3'h1;
          if (last) begin
            hs[F_SEQ] = 1'b1;
          end
        end
        default: begin
          res_d[0] = conv_data;
          run_d = 1'b0;
        end
      endcase
    end
    flag_d = flag_d | hs;
    // launch the next conversion while run stays set
    if (st_q == ST_IDLE && run_q && en_q) begin
      st_d = ST_WAIT;
      start_d = 1'b1;
      ch_d = (mode_q == MODE_SEQ) ? slot_ch_q[slot_q] : chsel_q;
    end
    // external trigger edge starts conversion like the run bit
    if (pins[0] && !trig_prev_q && en_q) begin
      run_d = 1'b1;
    end
    if (do_wr && wr_ok) begin
      m = merge(rmux(aw_a_q), w_d_q, wmask);
      case (aw_a_q)
        OFS_MAIN: begin
          en_d = m[0];
          mode_d = m[MODE_LSB +: 3];
          spd_d = m[SPEED_LSB +: 2];
          if (!m[0]) begin
            run_d = 1'b0; // disabling halts the sequencer
          end
        end
        OFS_CHAN: chsel_d = m[3:0];
        OFS_REP: begin
          cnt_d = m[CNT_W-1:0];
          accum_enable_d = m[ACCUM_ENABLE_BIT];
          if (w_s_q[1] && w_d_q[ACCCLR_BIT]) begin
            acc_d = '0;
          end
        end
        OFS_SEQL: begin
          for (int i = 0; i < 4; i++) begin
            slot_ch_d[i] = m[4*i +: 4];
          end
          len_d = m[LEN_LSB +: 3];
        end
        OFS_SEQH: begin
          for (int i = 0; i < 4; i++) begin
            slot_ch_d[i+4] = m[4*i +: 4];
          end
        end
        OFS_RUN: begin
          run_d = m[0];
          if (m[0] && !run_q) begin
            slot_d = '0;
            done_d = '0;
          end
        end
        OFS_CLR: begin
          // a zero clears its flag unless hardware sets it in this same cycle
          for (int i = F_CONV; i <= F_SEQ; i++) begin
            if (!m[i] && !hs[i]) begin
              flag_d[i] = 1'b0;
            end
          end
        end
        OFS_IEN: ien_d = m[3:0];
        default: begin
        end
      endcase
    end
  end

  // registered state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_v_q <= 1'b0;
      aw_a_q <= 8'h00;
      w_v_q <= 1'b0;
      w_d_q <= 32'h0000_0000;
      w_s_q <= 4'h0;
      bv_q <= 1'b0;
      br_q <= 2'b00;
      rv_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      rr_q <= 2'b00;
      en_q <= 1'b0;
      mode_q <= MODE_SINGLE;
      spd_q <= 2'b00;
      chsel_q <= 4'h0;
      cnt_q <= CNT_RST;
      accum_enable_q <= 1'b0;
      len_q <= 3'h0;
      slot_ch_q <= '{default: 4'h0};
      ien_q <= 4'h0;
      run_q <= 1'b0;
      flag_q <= 4'h0;
      acc_q <= 32'h0000_0000;
      res_q <= '{default: '0};
      slot_q <= 3'h0;
      st_q <= ST_IDLE;
      done_q <= '0;
      start_q <= 1'b0;
      ch_q <= 4'h0;
      trig_prev_q <= 1'b0;
    end else begin
      aw_v_q <= aw_v_d;
      aw_a_q <= aw_a_d;
      w_v_q <= w_v_d;
      w_d_q <= w_d_d;
      w_s_q <= w_s_d;
      bv_q <= bv_d;
      br_q <= br_d;
      rv_q <= rv_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
      en_q <= en_d;
      mode_q <= mode_d;
      spd_q <= spd_d;
      chsel_q <= chsel_d;
      cnt_q <= cnt_d;
      accum_enable_q <= accum_enable_d;
      len_q <= len_d;
      slot_ch_q <= slot_ch_d;
      ien_q <= ien_d;
      run_q <= run_d;
      flag_q <= flag_d;
      acc_q <= acc_d;
      res_q <= res_d;
      slot_q <= slot_d;
      st_q <= st_d;
      done_q <= done_d;
      start_q <= start_d;
      ch_q <= ch_d;
      trig_prev_q <= pins[0];
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic fin;
  assign fin = st_q == ST_WAIT && conv_done;

  repeat_end_a: assert property (fin && mode_q == MODE_REPEAT && done_q + 1'b1 >= cnt_q && !do_wr
    |=> !run_q && flag_q[F_ALL]) else $error("repeat end did not stop");
  irq_all_a: assert property ($rose(flag_q[F_ALL]) && ien_q[F_ALL] |-> irq)
    else $error("all-done irq missing");
  cont_run_a: assert property (fin && mode_q == MODE_CONT && run_q && !do_wr |=> run_q)
    else $error("continuous run cleared");
  slot_chan_a: assert property (start_q && mode_q == MODE_SEQ && !$past(do_wr)
    |-> ch_q == slot_ch_q[$past(slot_q)]) else $error("wrong slot channel");
  slot_len_a: assert property (fin && mode_q == MODE_SEQ && slot_q >= len_q && !do_wr
    |=> slot_q == 3'h0 && flag_q[F_SEQ]) else $error("pass end wrong");
  slot_store_a: assert property (fin && mode_q == MODE_SEQ
    |=> res_q[$past(slot_q)] == $past(conv_data)) else $error("slot result lost");
  accum_add_a: assert property (fin && mode_q == MODE_REPEAT && accum_enable_q && !do_wr
    |=> acc_q == $past(acc_q) + 32'($past(conv_data))) else $error("accumulate wrong");
  cnt_reset_a: assert property ($rose(aresetn) |-> cnt_q == CNT_RST)
    else $error("count reset wrong");
  acc_clear_a: assert property (do_wr && aw_a_q == OFS_REP && w_s_q[1] && w_d_q[ACCCLR_BIT]
    |=> acc_q == 32'h0000_0000) else $error("accumulator not cleared");
  done_set_a: assert property (fin |=> flag_q[F_CONV]) else $error("done flag missing");

  repeat_done_c: cover property (fin && mode_q == MODE_REPEAT ##1 flag_q[F_ALL]);
  seq_pass_c: cover property ($rose(flag_q[F_SEQ]) && len_q == 3'h7);
  cont_stop_c: cover property (mode_q == MODE_CONT && run_q ##1 !run_q);
endmodule : acs_top

//--- hw/acs_pkg.sv
// acs_pkg: shared constants for the conversion sequencer block
// How it works
// - repeat mode end: all-done, run clears, stop
// - all-done with enable raises interrupt request
// - mode 2 converts one channel until stopped
// - each conversion sets done, overwrites slot zero outside mode 3
// - mode 2 never clears run by itself
// - eight slots, each picks one of sixteen
// - length field enables slots zero through N
// - mode 3 cycles enabled slots until stopped
// - sequence result lands in its slot's register
// - pass end sets sequence-done, continues pass
// - repeat mode adds each result to accumulator
// - repeat count resets to one
package acs_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MAIN = 8'h00;   // main_control
  localparam logic [7:0] OFS_CHAN = 8'h04;   // channel_control
  localparam logic [7:0] OFS_REP = 8'h08;    // repeat_control
  localparam logic [7:0] OFS_SEQL = 8'h0C;   // sequence_config_low
  localparam logic [7:0] OFS_SEQH = 8'h10;   // sequence_config_high
  localparam logic [7:0] OFS_RUN = 8'h14;    // run bit
  localparam logic [7:0] OFS_STAT = 8'h18;   // flag_status
  localparam logic [7:0] OFS_CLR = 8'h1C;    // flag_clear
  localparam logic [7:0] OFS_IEN = 8'h20;    // irq_enable
  localparam logic [7:0] OFS_ACC = 8'h24;    // accumulator_result
  localparam logic [7:0] OFS_RES0 = 8'h40;   // result_slot_zero, slots follow
  // field positions
  localparam int MODE_LSB = 1;
  localparam int SPEED_LSB = 4;
  localparam int ACCUM_ENABLE_BIT = 8;
  localparam int ACCCLR_BIT = 9;
  localparam int LEN_LSB = 16;
  localparam int F_READY = 0;
  localparam int F_CONV = 1;
  localparam int F_ALL = 2;
  localparam int F_SEQ = 3;
  // reset values and sizes
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h01;
  localparam int SLOTS = 8;
  // conversion modes
  localparam logic [2:0] MODE_SINGLE = 3'h0;
  localparam logic [2:0] MODE_REPEAT = 3'h1;
  localparam logic [2:0] MODE_CONT = 3'h2;
  localparam logic [2:0] MODE_SEQ = 3'h3;
  typedef enum logic {ST_IDLE, ST_WAIT} acs_state_t;
endpackage : acs_pkg

//--- hw/acs_sync.sv
// acs_sync: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module acs_sync #(
  parameter int W = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q; // stage one is read only by stage two
  logic [W-1:0] lvl_d;
  // accept a change only when the last two stages agree
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end
  assign level = lvl_q;
endmodule : acs_sync

//--- tb/acs_core_model.sv
// acs_core_model: behavioural analog core and input mux seen from the sequencer
`timescale 1ns/1ps
module acs_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic core_enable,
  input wire logic conv_start,
  input wire logic [3:0] channel_select,
  input wire logic [7:0] lat,
  output logic core_ready,
  output logic conv_done,
  output logic [11:0] conv_data,
  output logic busy
);
  logic [7:0] cnt; // cycles left in the running conversion
  logic [3:0] ch; // channel latched at start
  logic [2:0] wake; // start-up delay after enable
  // one conversion at a time; data only valid in the done cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_ready <= 1'b0;
      conv_done <= 1'b0;
      conv_data <= 12'h0a5_5;
      busy <= 1'b0;
      cnt <= 8'h00;
      ch <= 4'h0;
      wake <= 3'h0;
    end else begin
      conv_done <= 1'b0;
      wake <= !core_enable ? 3'h0 : (wake == 3'h7 ? wake : wake + 3'h1);
      core_ready <= core_enable && (wake >= 3'h4);
      if (conv_start && !busy) begin
        busy <= 1'b1;
        cnt <= lat;
        ch <= channel_select;
      end else if (busy && cnt == 8'h00) begin
        busy <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= 12'h050 + {8'h00, ch}; // result names the channel
      end else if (busy) begin
        cnt <= cnt - 8'h01;
      end
      // released bus: show a changing pattern so stale data never matches
      if (!(busy && cnt == 8'h00)) begin
        conv_data <= ~conv_data;
      end
    end
  end
endmodule : acs_core_model

//--- tb/tb.sv
// tb: self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %0t got %h exp %h", $time, (g), (e)); end end
module tb;
  import acs_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, ext_trigger, core_ready, core_enable, conv_start, conv_done, irq, busy;
  logic [7:0] awaddr, araddr, lat;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, channel_select;
  logic [1:0] bresp, rresp, sample_speed, r;
  logic [11:0] conv_data;
  int err_total, num_checks;
  logic [3:0] chq[$]; // channels seen at each conversion start
  acs_top u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .ext_trigger(ext_trigger), .core_ready(core_ready), .core_enable(core_enable),
    .sample_speed(sample_speed), .conv_start(conv_start), .channel_select(channel_select),
    .conv_done(conv_done), .conv_data(conv_data), .irq(irq));
  acs_core_model u_core (.aclk(aclk), .aresetn(aresetn), .core_enable(core_enable),
    .conv_start(conv_start), .channel_select(channel_select), .lat(lat),
    .core_ready(core_ready), .conv_done(conv_done), .conv_data(conv_data), .busy(busy));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // record each start as it leaves the sequencer
  always @(posedge aclk) begin
    if (conv_start) chq.push_back(channel_select);
  end
  task summarize;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task timeout;
    err_total++;
    $display("BAD %0t wait ran out", $time);
    summarize();
  endtask : timeout
  // write: address and data offered together, bready held until answer
  task wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= v; bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin r = bresp; bready <= 1'b0; break; end
    end
    if (n == 100) timeout();
  endtask : wr
  task rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin d = rdata; r = rresp; rready <= 1'b0; break; end
    end
    if (n == 100) timeout();
  endtask : rd
  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(d, e)
  endtask : rc
  task wait_flag(input int b);
    int n;
    for (n = 0; n < 300; n++) begin rd(OFS_STAT); if (d[b] === 1'b1) break; end
    if (n == 300) timeout();
  endtask : wait_flag
  task wait_starts(input int k);
    int n;
    for (n = 0; n < 3000; n++) begin @(posedge aclk); if (chq.size() >= k) break; end
    if (n == 3000) timeout();
  endtask : wait_starts
  // stop and let the pending conversion drain
  task stop_run;
    int n;
    wr(OFS_RUN, 32'h0000_0000);
    for (n = 0; n < 300; n++) begin @(posedge aclk); if (!busy) break; end
    if (n == 300) timeout();
  endtask : stop_run
  function automatic logic [3:0] slot_ch(input int i);
    return 4'(15 - 2 * i);
  endfunction : slot_ch
  // repeat mode, count k, accumulator cleared before every run
  task repeat_case(input int k, input logic [7:0] l);
    lat <= l; chq.delete();
    wr(OFS_CHAN, 32'h0000_0004);
    wr(OFS_REP, 32'h0000_0300 | k);
    wr(OFS_IEN, 32'h0000_0004);
    wr(OFS_CLR, 32'h0000_0000);
    `CHK(irq, 1'b0)
    wr(OFS_MAIN, 32'h0000_0003);
    wr(OFS_RUN, 32'h0000_0001);
    wait_flag(F_ALL);
    rc(OFS_RUN, 32'h0000_0000);
    `CHK(chq.size(), k)
    rc(OFS_ACC, 32'h0000_0054 * k);
    `CHK(d / k, 32'h0000_0054)
    `CHK(irq, 1'b1)
    rc(OFS_RES0, 32'h0000_0054);
  endtask : repeat_case
  // continuous single channel started by the trigger pin
  task cont_case;
    int n;
    lat <= 8'h03; chq.delete();
    wr(OFS_CHAN, 32'h0000_0009);
    wr(OFS_CLR, 32'h0000_0000);
    rd(OFS_STAT);
    `CHK(d[F_CONV], 1'b0)
    wr(OFS_MAIN, 32'h0000_0025);
    `CHK(sample_speed, 2'b10)
    @(posedge aclk); ext_trigger <= 1'b1;
    repeat (6) @(posedge aclk);
    ext_trigger <= 1'b0;
    wait_starts(6);
    rc(OFS_RUN, 32'h0000_0001);
    rc(OFS_RES0, 32'h0000_0059);
    rd(OFS_STAT);
    `CHK(d[F_CONV], 1'b1)
    `CHK(chq[5], 4'h9)
    stop_run();
    n = chq.size();
    repeat (20) @(posedge aclk);
    `CHK(chq.size(), n)
  endtask : cont_case
  // continuous sequence over slots 0..len, two passes plus one start
  task seq_case(input int len, input logic [7:0] l);
    int k;
    lat <= l; chq.delete();
    wr(OFS_SEQH, {16'h0000, slot_ch(7), slot_ch(6), slot_ch(5), slot_ch(4)});
    wr(OFS_SEQL, {13'h0000, 3'(len), slot_ch(3), slot_ch(2), slot_ch(1), slot_ch(0)});
    wr(OFS_CLR, 32'h0000_0000);
    wr(OFS_MAIN, 32'h0000_0007);
    wr(OFS_RUN, 32'h0000_0001);
    wait_flag(F_SEQ);
    wait_starts(2 * (len + 1) + 1);
    stop_run();
    for (k = 0; k < 2 * (len + 1) + 1; k++) begin
      `CHK(chq[k], slot_ch(k % (len + 1)))
    end
    for (k = 0; k <= len; k++) begin
      rc(OFS_RES0 + 8'(4 * k), 32'h0000_0050 + slot_ch(k));
    end
  endtask : seq_case
  initial begin
    aresetn = 1'b0; awvalid = 1'b0; awaddr = 8'h00; wvalid = 1'b0; wdata = 32'h0000_0000;
    wstrb = 4'hf; bready = 1'b0; arvalid = 1'b0; araddr = 8'h00; rready = 1'b0;
    ext_trigger = 1'b0; lat = 8'h01; err_total = 0; num_checks = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rc(OFS_REP, 32'h0000_0001);
    rc(8'h28, 32'h0000_0000);
    `CHK(r, 2'b10)
    wr(8'h28, 32'h0000_0001);
    `CHK(r, 2'b10)
    wr(OFS_MAIN, 32'h0000_0001);
    `CHK(r, 2'b00)
    wait_flag(F_READY);
    repeat_case(2, 8'h00);
    repeat_case(3, 8'h09);
    cont_case();
    seq_case(0, 8'h00);
    seq_case(3, 8'h05);
    seq_case(7, 8'h01);
    wr(OFS_MAIN, 32'h0000_0000);
    @(posedge aclk);
    `CHK(core_enable, 1'b0)
    summarize();
  end
endmodule : tb
